/* File: dv/rsl_host.sv */
// Host model issuing single byte register accesses
module rsl_host (
	input wire logic clock,
	output rsl_pkg::rsl_req_t req,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	timeunit 1ns;
	timeprecision 1ns;
	initial req = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		req <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int n;
		@(posedge clock);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clock);
		req <= '0;
		n = 0;
		#1;
		while (rvalid !== 1'b1 && n < 4) begin
			@(posedge clock);
			#1;
			n++;
		end
		d = rdata;
		if (n == 4) begin
			testbench.err_total++;
			testbench.tally_and_finish();
		end
	endtask : rd
endmodule : rsl_host

/* File: dv/rsl_regs_monitor.sv */
// Port checker for the register bank
module rsl_regs_monitor (
	input wire logic clock,
	input wire logic sys_rst,
	input wire rsl_pkg::rsl_req_t host_req,
	input wire logic [7:0] host_rdata,
	input wire logic host_rvalid,
	input wire logic [7:0] current_sense_input,
	input wire logic [4:0] limit_resistor_pin,
	input wire logic overcurrent_summary_flag,
	input wire logic alert,
	input wire logic limit_sense_enable,
	input wire rsl_pkg::rsl_apply_t applied
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	rd_answer_a: assert property (host_req.rd |=> host_rvalid)
		else $error("read not answered");
	stray_valid_a: assert property (!host_req.rd |=> !host_rvalid)
		else $error("read valid without read");
	alert_mirror_a: assert property (alert == overcurrent_summary_flag)
		else $error("alert differs from flag");
	limit_decode_a: assert property (applied.limit_mv == 16'h00C8 + 16'h0032 * applied.limit_code)
		else $error("limit decode wrong");
	ramp_fine_a: assert property (applied.ramp_code < 4'h6 |->
		applied.ramp_time_us == (applied.ramp_code + 16'h0001) * 16'h0096)
		else $error("fine ramp time wrong");
	ramp_coarse_a: assert property (applied.ramp_code >= 4'h6 |->
		applied.ramp_time_us == (applied.ramp_code - 16'h0005) * 16'h03E8)
		else $error("coarse ramp time wrong");
	limit_follow_a: assert property ((limit_sense_enable && $stable(limit_resistor_pin)) [*4]
		|-> applied.limit_code == limit_resistor_pin)
		else $error("resistor limit not followed");
	warn_steady_a: assert property ((!host_req.wr && $stable(current_sense_input)) [*5] |-> $stable(alert))
		else $error("warning moved without cause");
	reset_clear_a: assert property (disable iff (1'b0) sys_rst |=> !host_rvalid && !alert && host_rdata == 8'h00)
		else $error("reset did not clear outputs");
	summary_read_a: assert property (host_req.rd && host_req.addr == 8'h21
		|=> host_rdata == {3'h0, $past(alert), 4'h0})
		else $error("summary byte differs from alert");
	lock_read_a: assert property (host_req.rd && host_req.addr == 8'h2A |=> host_rdata[7:1] == 7'h00)
		else $error("lock register reserved bits not zero");
	cover property (host_req.rd);
	cover property (host_req.wr && host_req.addr == 8'h2A);
	cover property ($rose(alert));
	cover property ($fell(limit_sense_enable));
endmodule : rsl_regs_monitor

bind rsl_regs rsl_regs_monitor rsl_regs_monitor_inst (.clock(clock), .sys_rst(sys_rst), .host_req(host_req),
	.host_rdata(host_rdata), .host_rvalid(host_rvalid), .current_sense_input(current_sense_input),
	.limit_resistor_pin(limit_resistor_pin), .overcurrent_summary_flag(overcurrent_summary_flag),
	.alert(alert), .limit_sense_enable(limit_sense_enable), .applied(applied));

/* File: dv/testbench.sv */
// Self-checking bench for the register bank
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic por_done = 1'b0;
	logic [7:0] sense = 8'h00;
	logic [7:0] ocl_ev = 8'h00;
	logic [3:0] ramp_pin = 4'h9;
	logic [4:0] lim_pin = 5'h03;
	rsl_pkg::rsl_req_t req;
	logic [7:0] rdata;
	logic rvalid, oc_flag, alert, lse;
	rsl_pkg::rsl_apply_t app;
	int err_total = 0;
	int tests_run = 0;
	rsl_regs rsl_regs_inst (.clock(clock), .sys_rst(sys_rst), .por_done(por_done), .host_req(req),
		.host_rdata(rdata), .host_rvalid(rvalid), .current_sense_input(sense), .ramp_select_pin(ramp_pin),
		.limit_resistor_pin(lim_pin), .current_limit_event(ocl_ev), .overcurrent_summary_flag(oc_flag),
		.alert(alert), .limit_sense_enable(lse), .applied(app));
	rsl_host rsl_host_inst (.clock(clock), .req(req), .rdata(rdata), .rvalid(rvalid));
	initial begin
		forever #5 clock = ~clock;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rsl_host_inst.rd(a, d);
		chk({8'h00, d}, {8'h00, exp});
	endtask : rchk
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish
	task automatic s_reset();
		rchk(8'h20, 8'hFF);
		rchk(8'h24, 8'h00);
		rchk(8'h30, 8'h00);
		rchk(8'h2B, 8'h09);
		@(posedge clock);
		ramp_pin <= 4'h2;
		repeat (6) @(posedge clock);
		rchk(8'h2B, 8'h09);
	endtask : s_reset
	task automatic s_warn();
		rsl_host_inst.wr(8'h20, 8'h40);
		@(posedge clock);
		sense <= 8'h41;
		repeat (6) @(posedge clock);
		rchk(8'h24, 8'h01);
		rchk(8'h21, 8'h10);
		rchk(8'h26, 8'h41);
		chk({15'h0000, alert}, 16'h0001);
		chk({15'h0000, oc_flag}, 16'h0001);
		@(posedge clock);
		sense <= 8'h40;
		repeat (6) @(posedge clock);
		rchk(8'h24, 8'h00);
		chk({14'h0000, oc_flag, alert}, 16'h0000);
	endtask : s_warn
	task automatic s_ramp();
		rsl_host_inst.wr(8'h2C, 8'h5A);
		rchk(8'h2C, 8'h0A);
		chk({12'h000, app.ramp_code}, 16'h0009);
		rsl_host_inst.wr(8'h46, 8'h01);
		rchk(8'h2B, 8'h09);
		chk(app.ramp_time_us, 16'h1388);
		rsl_host_inst.wr(8'h2C, 8'h05);
		rchk(8'h2C, 8'h05);
		chk(app.ramp_time_us, 16'h0384);
	endtask : s_ramp
	task automatic s_limit();
		chk({11'h000, lse, app.limit_code}, 16'h0023);
		@(posedge clock);
		lim_pin <= 5'h11;
		repeat (5) @(posedge clock);
		chk({11'h000, lse, app.limit_code}, 16'h0031);
		rsl_host_inst.wr(8'h2E, 8'hFF);
		rchk(8'h2E, 8'h1F);
		rsl_host_inst.wr(8'h47, 8'h02);
		rchk(8'h2D, 8'h00);
		chk({15'h0000, lse}, 16'h0000);
		chk(app.limit_mv, 16'h06D6);
		@(posedge clock);
		lim_pin <= 5'h03;
		repeat (5) @(posedge clock);
		chk({11'h000, app.limit_code}, 16'h001F);
	endtask : s_limit
	task automatic s_lock();
		@(posedge clock);
		ocl_ev <= 8'h81;
		rsl_host_inst.wr(8'h2A, 8'h03);
		rchk(8'h2A, 8'h01);
		rsl_host_inst.wr(8'h20, 8'h00);
		rchk(8'h20, 8'h40);
		rsl_host_inst.wr(8'h2A, 8'h00);
		rchk(8'h2A, 8'h01);
		rsl_host_inst.wr(8'h2C, 8'h0F);
		rchk(8'h2C, 8'h05);
		rsl_host_inst.wr(8'h47, 8'h00);
		rchk(8'h47, 8'h02);
		rchk(8'h2D, 8'h81);
	endtask : s_lock
	task automatic s_power();
		@(posedge clock);
		sys_rst <= 1'b1;
		por_done <= 1'b0;
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		por_done <= 1'b1;
		repeat (6) @(posedge clock);
		rchk(8'h2A, 8'h00);
		rchk(8'h20, 8'hFF);
		rchk(8'h2B, 8'h02);
		chk({11'h000, lse, app.limit_code}, 16'h0023);
	endtask : s_power
	initial begin
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		por_done <= 1'b1;
		repeat (6) @(posedge clock);
		s_reset();
		s_warn();
		s_ramp();
		s_limit();
		s_lock();
		s_power();
		tally_and_finish();
	end
endmodule : testbench

/* File: inc/rsl_pkg.sv */
// Package for the regulator status and lock register bank
package rsl_pkg;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_WARN_LIMIT = 8'h20;
	localparam logic [7:0] ADDR_SUMMARY = 8'h21;
	localparam logic [7:0] ADDR_WARN_STATUS = 8'h24;
	localparam logic [7:0] ADDR_READBACK = 8'h26;
	localparam logic [7:0] ADDR_LOCK = 8'h2A;
	localparam logic [7:0] ADDR_RAMP_STATUS = 8'h2B;
	localparam logic [7:0] ADDR_RAMP_CONFIG = 8'h2C;
	localparam logic [7:0] ADDR_PHASE_STATUS = 8'h2D;
	localparam logic [7:0] ADDR_PHASE_CONFIG = 8'h2E;
	localparam logic [7:0] ADDR_LATCH_A = 8'h46;
	localparam logic [7:0] ADDR_LATCH_B = 8'h47;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int WARN_BIT = 0;
	localparam int LOCK_BIT = 0;
	localparam int SUMMARY_OC_BIT = 4;
	localparam int RAMP_SEL_BIT = 0;
	localparam int LIMIT_SEL_BIT = 1;
	localparam logic [7:0] WARN_LIMIT_RST = 8'hFF;
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [3:0] RAMP_RST = 4'h0;
	localparam logic [4:0] LIMIT_RST = 5'h00;

	// ---------------------------------------------------------------
	// Ramp and threshold scaling
	// ---------------------------------------------------------------
	localparam logic [15:0] RAMP_FINE_STEP_US = 16'h0096;
	localparam logic [15:0] RAMP_MID_US = 16'h03E8;
	localparam logic [3:0] RAMP_MID_CODE = 4'h6;
	localparam logic [15:0] LIMIT_BASE_MV = 16'h00C8;
	localparam logic [15:0] LIMIT_STEP_MV = 16'h0032;

	// Host register access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rsl_req_t;

	// Settings applied to the regulator
	typedef struct packed {
		logic [3:0] ramp_code;
		logic [15:0] ramp_time_us;
		logic [4:0] limit_code;
		logic [15:0] limit_mv;
	} rsl_apply_t;

endpackage : rsl_pkg

/* File: logic/rsl_regs.sv */
// Status, readback, lock, ramp and phase limit register bank
module rsl_regs (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic por_done,
	input wire rsl_pkg::rsl_req_t host_req,
	output logic [7:0] host_rdata,
	output logic host_rvalid,
	input wire logic [7:0] current_sense_input,
	input wire logic [3:0] ramp_select_pin,
	input wire logic [4:0] limit_resistor_pin,
	input wire logic [7:0] current_limit_event,
	output logic overcurrent_summary_flag,
	output logic alert,
	output logic limit_sense_enable,
	output rsl_pkg::rsl_apply_t applied
);

	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------
	function automatic logic [15:0] ramp_us(input logic [3:0] code);
		logic [15:0] c;
		c = {12'h000, code};
		if (code < rsl_pkg::RAMP_MID_CODE)
			ramp_us = 16'((c + 16'h0001) * rsl_pkg::RAMP_FINE_STEP_US);
		else
			ramp_us = 16'((c - 16'h0005) * rsl_pkg::RAMP_MID_US);
	endfunction : ramp_us

	function automatic logic [15:0] limit_mv(input logic [4:0] code);
		limit_mv = 16'(rsl_pkg::LIMIT_BASE_MV + {11'h000, code} * rsl_pkg::LIMIT_STEP_MV);
	endfunction : limit_mv

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	logic [7:0] sense_s1_r, sense_s2_r;
	logic [3:0] ramp_s1_r, ramp_s2_r;
	logic [4:0] lim_s1_r, lim_s2_r;
	logic [7:0] ev_s1_r, ev_s2_r;
	logic por_s1_r, por_s2_r;

	always_ff @(posedge clock) begin
		sense_s1_r <= current_sense_input;
		sense_s2_r <= sense_s1_r;
		ramp_s1_r <= ramp_select_pin;
		ramp_s2_r <= ramp_s1_r;
		lim_s1_r <= limit_resistor_pin;
		lim_s2_r <= lim_s1_r;
		ev_s1_r <= current_limit_event;
		ev_s2_r <= ev_s1_r;
		if (sys_rst) begin
			por_s1_r <= 1'b0;
			por_s2_r <= 1'b0;
		end else begin
			por_s1_r <= por_done;
			por_s2_r <= por_s1_r;
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [7:0] warn_limit_r;
	logic [7:0] readback_r;
	logic warn_r;
	logic lock_r;
	logic [3:0] ramp_status_r;
	logic ramp_captured_r;
	logic [3:0] ramp_cfg_r;
	logic [4:0] limit_cfg_r;
	logic [7:0] latch_a_r, latch_b_r;
	logic [7:0] phase_stat_r;
	logic [7:0] rdata_r;
	logic rvalid_r;
	rsl_pkg::rsl_apply_t applied_r;
	rsl_pkg::rsl_apply_t applied_nxt;

	// ---------------------------------------------------------------
	// Write decode
	// ---------------------------------------------------------------
	wire wr_limit = host_req.wr && host_req.addr == rsl_pkg::ADDR_WARN_LIMIT;
	wire wr_lock = host_req.wr && host_req.addr == rsl_pkg::ADDR_LOCK;
	wire wr_ramp = host_req.wr && host_req.addr == rsl_pkg::ADDR_RAMP_CONFIG;
	wire wr_phase = host_req.wr && host_req.addr == rsl_pkg::ADDR_PHASE_CONFIG;
	wire wr_la = host_req.wr && host_req.addr == rsl_pkg::ADDR_LATCH_A;
	wire wr_lb = host_req.wr && host_req.addr == rsl_pkg::ADDR_LATCH_B;
	wire wr_open = !lock_r;

	wire we_limit = wr_limit && wr_open;
	wire we_ramp = wr_ramp && wr_open;
	wire we_phase = wr_phase && wr_open;
	wire we_la = wr_la && wr_open;
	wire we_lb = wr_lb && wr_open;

	// ---------------------------------------------------------------
	// Compare and selection
	// ---------------------------------------------------------------
	// threshold compare
	wire over_limit = readback_r > warn_limit_r;

	wire ramp_sel = latch_a_r[rsl_pkg::RAMP_SEL_BIT] | latch_b_r[rsl_pkg::RAMP_SEL_BIT];
	wire lim_sel = latch_a_r[rsl_pkg::LIMIT_SEL_BIT] | latch_b_r[rsl_pkg::LIMIT_SEL_BIT];
	wire [3:0] ramp_use = ramp_sel ? ramp_cfg_r : ramp_status_r;
	wire [4:0] lim_use = lim_sel ? limit_cfg_r : lim_s2_r;

	// ---------------------------------------------------------------
	// Sensed values
	// ---------------------------------------------------------------
	// sense code readback
	always_ff @(posedge clock) begin
		if (sys_rst)
			readback_r <= rsl_pkg::CONFIG_RST;
		else
			readback_r <= sense_s2_r;
	end

	// warning flag, a level that follows the compare
	always_ff @(posedge clock) begin
		if (sys_rst)
			warn_r <= 1'b0;
		else
			warn_r <= over_limit;
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			phase_stat_r <= rsl_pkg::CONFIG_RST;
		else
			phase_stat_r <= ev_s2_r;
	end

	// capture at power-on, once only
	// A later pin change is not seen until power is cycled
	wire ramp_take = por_s2_r && !ramp_captured_r;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ramp_status_r <= rsl_pkg::RAMP_RST;
			ramp_captured_r <= 1'b0;
		end else if (ramp_take) begin
			ramp_status_r <= ramp_s2_r;
			ramp_captured_r <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Host written registers
	// ---------------------------------------------------------------
	// lockable threshold
	always_ff @(posedge clock) begin
		if (sys_rst)
			warn_limit_r <= rsl_pkg::WARN_LIMIT_RST;
		else if (we_limit)
			warn_limit_r <= host_req.wdata;
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			ramp_cfg_r <= rsl_pkg::RAMP_RST;
		else if (we_ramp)
			ramp_cfg_r <= host_req.wdata[3:0];
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			limit_cfg_r <= rsl_pkg::LIMIT_RST;
		else if (we_phase)
			limit_cfg_r <= host_req.wdata[4:0];
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			latch_a_r <= rsl_pkg::CONFIG_RST;
		else if (we_la)
			latch_a_r <= host_req.wdata;
	end

	// Either latch may carry the select bits
	always_ff @(posedge clock) begin
		if (sys_rst)
			latch_b_r <= rsl_pkg::CONFIG_RST;
		else if (we_lb)
			latch_b_r <= host_req.wdata;
	end

	// ---------------------------------------------------------------
	// Write lock
	// ---------------------------------------------------------------
	// Lock cleared only by power-on, sys_rst being that event
	always_ff @(posedge clock) begin
		if (sys_rst)
			lock_r <= 1'b0;
		else if (wr_lock && host_req.wdata[rsl_pkg::LOCK_BIT])
			lock_r <= 1'b1;
	end

	// ---------------------------------------------------------------
	// Read mux
	// ---------------------------------------------------------------
	// reserved bits read zero
	wire [7:0] view_summary = 8'(warn_r) << rsl_pkg::SUMMARY_OC_BIT;
	wire [7:0] view_warn = {7'h00, warn_r};
	wire [7:0] view_lock = {7'h00, lock_r};
	wire [7:0] view_ramp_status = {4'h0, ramp_status_r};
	wire [7:0] view_ramp_cfg = {4'h0, ramp_cfg_r};
	wire [7:0] view_phase_cfg = {3'h0, limit_cfg_r};

	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		unique case (host_req.addr)
			rsl_pkg::ADDR_WARN_LIMIT: rd_mux = warn_limit_r;
			rsl_pkg::ADDR_SUMMARY: rd_mux = view_summary;
			rsl_pkg::ADDR_WARN_STATUS: rd_mux = view_warn;
			rsl_pkg::ADDR_READBACK: rd_mux = readback_r;
			rsl_pkg::ADDR_LOCK: rd_mux = view_lock;
			rsl_pkg::ADDR_RAMP_STATUS: rd_mux = view_ramp_status;
			rsl_pkg::ADDR_RAMP_CONFIG: rd_mux = view_ramp_cfg;
			rsl_pkg::ADDR_PHASE_STATUS: rd_mux = phase_stat_r;
			rsl_pkg::ADDR_PHASE_CONFIG: rd_mux = view_phase_cfg;
			rsl_pkg::ADDR_LATCH_A: rd_mux = latch_a_r;
			rsl_pkg::ADDR_LATCH_B: rd_mux = latch_b_r;
			// Unmapped addresses read zero
			default: rd_mux = 8'h00;
		endcase
	end

	// One cycle answer to each read strobe
	always_ff @(posedge clock) begin
		if (sys_rst)
			rvalid_r <= 1'b0;
		else
			rvalid_r <= host_req.rd;
	end

	// Read data holds until the next read
	always_ff @(posedge clock) begin
		if (sys_rst)
			rdata_r <= 8'h00;
		else if (host_req.rd)
			rdata_r <= rd_mux;
	end

	// ---------------------------------------------------------------
	// Applied settings
	// ---------------------------------------------------------------
	// decoded settings for the regulator
	assign applied_nxt = '{
		ramp_code: ramp_use,
		ramp_time_us: ramp_us(ramp_use),
		limit_code: lim_use,
		limit_mv: limit_mv(lim_use)
	};

	// Codes and decoded values move together in one register
	always_ff @(posedge clock) begin
		applied_r <= applied_nxt;
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign host_rdata = rdata_r;
	assign host_rvalid = rvalid_r;

	assign overcurrent_summary_flag = warn_r;
	assign alert = warn_r;
	// current source on while the resistor sets the limit
	assign limit_sense_enable = !lim_sel;
	assign applied = applied_r;

endmodule : rsl_regs
